// ===== hall_comp_linearizer.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Scale field by polarity, coarse, fine, tempco factor
// [R2] Warm set at or above 25, cool below
// [R3] deltaT is ambient minus 25 degrees
// [R4] Sensitivity result is 17-bit signed
// [R5] Add fine offset plus drift times deltaT
// [R6] Offset result is 13-bit signed
// [R7] Polarity from gain trim bit 15
// [R8] Coarse bits 14:12, fine bits 10:0
// [R9] First-order gain tempco, warm 10:0, cool 22:12
// [R10] Second-order gain tempco, warm 9:0, cool 21:12
// [R11] Fine offset from bits 15:0
// [R12] Offset drift, warm 11:0, cool 23:12
// [R13] Seventeen programmable 12-bit x points
// [R14] Fixed y points from -2048, step 256
// [R15] Software keeps x points non-decreasing
// [R16] Equal adjacent points produce an output jump
// [R17] Interpolating and binning table modes
// [R18] Interpolate linearly inside a segment
// [R19] Below first point extrapolate, floor -2304
// [R20] Above last point extrapolate, ceiling +2304
// [R21] One extra segment beyond each range end
// [R22] Linearization result is 13-bit signed
// [R23] Bin mode outputs y of nearest lower point
// [R24] Table used only when enable bit set
// [R25] Bit 14 inverts output, bit 15 input
// [R26] Ambient temperature held with each sample
// [R27] Saturate stage results instead of wrapping
module hall_comp_linearizer #(
    parameter int TC_FRAC = 8,
    parameter int DRIFT_FRAC = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleValid,
    input wire hall_comp_pkg::sample_s sampleIn,
    output logic resultValid,
    output hall_comp_pkg::result_s resultOut
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic signed [63:0] clampTo(input logic signed [63:0] v,
                                                   input logic signed [63:0] lo,
                                                   input logic signed [63:0] hi);
        clampTo = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [23:0] laneMerge(input logic [23:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [23:0] r;
        r = old;
        for (int b = 0; b < 3; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        laneMerge = r;
    endfunction

    localparam logic signed [63:0] SENS_MAXV = 64'sd65535;
    localparam logic signed [63:0] SENS_MINV = -64'sd65536;
    localparam logic signed [63:0] COMP_MAXV = 64'sd4095;
    localparam logic signed [63:0] COMP_MINV = -64'sd4096;

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [23:0] gainTrim_q;
    logic [23:0] gainTc1_q;
    logic [23:0] gainTc2_q;
    logic [23:0] offsetTrim_q;
    logic [23:0] offsetDrift_q;
    logic [23:0] linReg_q [hall_comp_pkg::LIN_REGS];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [9:0] regIdx;
    logic accessDone;
    logic writeDone;
    logic mapped;
    logic [23:0] readWord;
    logic signed [12:0] compOut_q;
    logic signed [12:0] linOut_q;
    logic resultValid_q;

    assign regIdx = paddr[11:2];
    // Extra wait cycle keeps all bus outputs straight from flip-flops
    assign accessDone = psel && penable && pready_q;
    assign writeDone = accessDone && pwrite && mapped;

    always_comb begin
        mapped = 1'b1;
        readWord = 24'h000000;
        case (regIdx)
            hall_comp_pkg::IDX_GAIN_TRIM: readWord = gainTrim_q;
            hall_comp_pkg::IDX_GAIN_TC1: readWord = gainTc1_q;
            hall_comp_pkg::IDX_GAIN_TC2: readWord = gainTc2_q;
            hall_comp_pkg::IDX_OFFSET_TRIM: readWord = offsetTrim_q;
            hall_comp_pkg::IDX_OFFSET_DRIFT: readWord = offsetDrift_q;
            hall_comp_pkg::IDX_STATUS: readWord = 24'h000000;
            default: begin
                if (regIdx >= hall_comp_pkg::IDX_LIN_FIRST
                    && regIdx <= hall_comp_pkg::IDX_LIN_LAST) begin
                    readWord = linReg_q[4'(regIdx - hall_comp_pkg::IDX_LIN_FIRST)];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q) begin
                if (pwrite || !mapped) begin
                    prdata_q <= 32'h00000000;
                end else if (regIdx == hall_comp_pkg::IDX_STATUS) begin
                    prdata_q <= 32'h00000000;
                    prdata_q[hall_comp_pkg::STATUS_LIN_LSB +: 13] <= linOut_q;
                    prdata_q[hall_comp_pkg::STATUS_COMP_LSB +: 13] <= compOut_q;
                end else begin
                    prdata_q <= {8'h00, readWord};
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gainTrim_q <= hall_comp_pkg::RST_GAIN_TRIM;
            gainTc1_q <= hall_comp_pkg::RST_GAIN_TC1;
            gainTc2_q <= hall_comp_pkg::RST_GAIN_TC2;
            offsetTrim_q <= hall_comp_pkg::RST_OFFSET_TRIM;
            offsetDrift_q <= hall_comp_pkg::RST_OFFSET_DRIFT;
        end else if (writeDone) begin
            case (regIdx)
                hall_comp_pkg::IDX_GAIN_TRIM: gainTrim_q <= laneMerge(gainTrim_q, pwdata, pstrb);
                hall_comp_pkg::IDX_GAIN_TC1: gainTc1_q <= laneMerge(gainTc1_q, pwdata, pstrb);
                hall_comp_pkg::IDX_GAIN_TC2: gainTc2_q <= laneMerge(gainTc2_q, pwdata, pstrb);
                hall_comp_pkg::IDX_OFFSET_TRIM:
                    offsetTrim_q <= laneMerge(offsetTrim_q, pwdata, pstrb);
                hall_comp_pkg::IDX_OFFSET_DRIFT:
                    offsetDrift_q <= laneMerge(offsetDrift_q, pwdata, pstrb);
                default: ;
            endcase
        end
    end

    for (genvar g = 0; g < hall_comp_pkg::LIN_REGS; g++) begin : g_linReg
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                linReg_q[g] <= hall_comp_pkg::RST_LIN;
            end else if (writeDone
                         && regIdx == hall_comp_pkg::IDX_LIN_FIRST + 10'(g)) begin
                linReg_q[g] <= laneMerge(linReg_q[g], pwdata, pstrb);
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    logic signed [11:0] xTab [hall_comp_pkg::LIN_POINTS];
    for (genvar p = 0; p < hall_comp_pkg::LIN_POINTS; p++) begin : g_xTab
        if (p % 2 == 0) begin : g_even
            assign xTab[p] = linReg_q[p/2][hall_comp_pkg::LIN_EVEN_LSB +: 12]; // [R13]
        end else begin : g_odd
            assign xTab[p] = linReg_q[p/2][hall_comp_pkg::LIN_ODD_LSB +: 12]; // [R13]
        end
    end

    logic [23:0] linCtrl;
    assign linCtrl = linReg_q[hall_comp_pkg::LIN_REGS-1];

    ////////////////////////////////////////////////////////////////////////////
    // Stage 1: sensitivity trim

    logic signed [9:0] deltaT;
    logic warm;
    logic signed [63:0] tc1;
    logic signed [63:0] tc2;
    logic signed [63:0] tcTerm;
    logic signed [63:0] factor;
    logic signed [63:0] scaled;
    logic [2:0] coarse;
    logic signed [16:0] sens_q;
    logic signed [9:0] deltaT_q;
    logic s1Valid_q;

    assign deltaT = 10'(sampleIn.tempC) - 10'(hall_comp_pkg::REF_TEMP_C); // [R3] [R26]
    assign warm = !deltaT[9]; // [R2]
    assign coarse = gainTrim_q[hall_comp_pkg::COARSE_LSB +: 3]; // [R8]

    always_comb begin
        tc1 = warm ? 64'(signed'(gainTc1_q[hall_comp_pkg::TC1_WARM_LSB +: 11]))
                   : 64'(signed'(gainTc1_q[hall_comp_pkg::TC1_COOL_LSB +: 11])); // [R9]
        tc2 = warm ? 64'(signed'(gainTc2_q[hall_comp_pkg::TC2_WARM_LSB +: 10]))
                   : 64'(signed'(gainTc2_q[hall_comp_pkg::TC2_COOL_LSB +: 10])); // [R10]
        // Tempco scaled by 1000*100 so the integer divide happens once
        tcTerm = (tc2 * 64'(deltaT) + tc1 * 64'(hall_comp_pkg::TC2_DIV)) * 64'(deltaT);
        factor = (64'sd1 <<< hall_comp_pkg::FACTOR_FRAC)
                 + (tcTerm <<< hall_comp_pkg::FACTOR_FRAC)
                   / (64'(hall_comp_pkg::TC2_DIV * hall_comp_pkg::TC_DIV) <<< TC_FRAC); // [R1]
        scaled = 64'(sampleIn.field)
                 * 64'(hall_comp_pkg::FINE_HALF + int'(gainTrim_q[hall_comp_pkg::FINE_LSB +: 11]));
        scaled = scaled <<< ((coarse > 3'(hall_comp_pkg::COARSE_MAX_SHIFT))
                             ? hall_comp_pkg::COARSE_MAX_SHIFT : int'(coarse)); // [R8]
        scaled = (scaled * factor) >>> (hall_comp_pkg::FINE_SHIFT + hall_comp_pkg::FACTOR_FRAC);
        if (gainTrim_q[hall_comp_pkg::POL_BIT]) begin
            scaled = -scaled; // [R7]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sens_q <= 17'sd0;
            deltaT_q <= 10'sd0;
            s1Valid_q <= 1'b0;
        end else begin
            s1Valid_q <= sampleValid;
            if (sampleValid) begin
                sens_q <= 17'(clampTo(scaled, SENS_MINV, SENS_MAXV)); // [R4] [R27]
                deltaT_q <= deltaT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 2: offset trim

    logic signed [63:0] drift;
    logic signed [63:0] offSum;
    logic s2Valid_q;

    always_comb begin
        drift = !deltaT_q[9]
                ? 64'(signed'(offsetDrift_q[hall_comp_pkg::DRIFT_WARM_LSB +: 12]))
                : 64'(signed'(offsetDrift_q[hall_comp_pkg::DRIFT_COOL_LSB +: 12])); // [R12] [R2]
        offSum = 64'(sens_q)
                 + 64'(signed'(offsetTrim_q[hall_comp_pkg::FINE_OFFSET_LSB +: 16])) // [R11]
                 + ((drift * 64'(deltaT_q)) >>> DRIFT_FRAC); // [R5]
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            compOut_q <= 13'sd0;
            s2Valid_q <= 1'b0;
        end else begin
            s2Valid_q <= s1Valid_q;
            if (s1Valid_q) begin
                compOut_q <= 13'(clampTo(offSum, COMP_MINV, COMP_MAXV)); // [R6] [R27]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 3: find segment

    logic signed [13:0] linIn;
    logic [4:0] count;
    logic signed [13:0] linIn_q;
    logic [4:0] count_q;
    logic s3Valid_q;

    always_comb begin
        linIn = linCtrl[hall_comp_pkg::LIN_IN_INV_BIT] ? -14'(compOut_q) : 14'(compOut_q); // [R25]
        count = 5'd0;
        // Points at or below input; equal points are passed together, giving the jump
        for (int i = 0; i < hall_comp_pkg::LIN_POINTS; i++) begin
            if (14'(xTab[i]) <= linIn) begin
                count = count + 5'd1; // [R16] [R15]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            linIn_q <= 14'sd0;
            count_q <= 5'd0;
            s3Valid_q <= 1'b0;
        end else begin
            s3Valid_q <= s2Valid_q;
            if (s2Valid_q) begin
                linIn_q <= linIn;
                count_q <= count;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stage 4: map through table

    logic [4:0] loIdx;
    logic [4:0] hiIdx;
    logic signed [31:0] base;
    logic signed [31:0] den;
    logic signed [63:0] yVal;

    always_comb begin
        if (count_q == 5'd0) begin
            loIdx = 5'd0;
            hiIdx = 5'd1; // [R19]
        end else if (count_q == 5'(hall_comp_pkg::LIN_POINTS)) begin
            loIdx = 5'(hall_comp_pkg::LIN_POINTS - 2);
            hiIdx = 5'(hall_comp_pkg::LIN_POINTS - 1); // [R20]
        end else begin
            loIdx = count_q - 5'd1;
            hiIdx = count_q; // [R18]
        end
        base = 32'(hall_comp_pkg::Y_FIRST) + 32'(hall_comp_pkg::Y_STEP) * 32'(loIdx); // [R14]
        den = 32'(xTab[hiIdx]) - 32'(xTab[loIdx]);
        if (!linCtrl[hall_comp_pkg::LIN_ENABLE_BIT]) begin
            yVal = 64'(linIn_q); // [R24]
        end else if (linCtrl[hall_comp_pkg::LIN_BIN_BIT]) begin
            yVal = (count_q == 5'd0) ? 64'(hall_comp_pkg::Y_MIN)
                   : 64'(hall_comp_pkg::Y_FIRST)
                     + 64'(hall_comp_pkg::Y_STEP) * 64'(count_q - 5'd1); // [R23] [R17]
        end else if (den == 32'sd0) begin
            // Only reachable at the outer ends, where the limit is the answer
            yVal = (count_q == 5'd0) ? 64'(hall_comp_pkg::Y_MIN) : 64'(hall_comp_pkg::Y_MAX);
        end else begin
            yVal = 64'(base + (32'(hall_comp_pkg::Y_STEP) * (32'(linIn_q) - 32'(xTab[loIdx])))
                              / den); // [R18] [R17]
            yVal = clampTo(yVal, 64'(hall_comp_pkg::Y_MIN), 64'(hall_comp_pkg::Y_MAX)); // [R21]
        end
        if (linCtrl[hall_comp_pkg::LIN_OUT_INV_BIT]) begin
            yVal = -yVal; // [R25]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            linOut_q <= 13'sd0;
            resultValid_q <= 1'b0;
        end else begin
            resultValid_q <= s3Valid_q;
            if (s3Valid_q) begin
                linOut_q <= 13'(clampTo(yVal, COMP_MINV, COMP_MAXV)); // [R22] [R27]
            end
        end
    end

    assign resultValid = resultValid_q;
    assign resultOut.comp = compOut_q;
    assign resultOut.lin = linOut_q;

endmodule // hall_comp_linearizer

// ===== hall_comp_monitor.sv
`timescale 1ns/1ps
module hall_comp_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleValid,
    input wire hall_comp_pkg::sample_s sampleIn,
    input wire logic resultValid,
    input wire hall_comp_pkg::result_s resultOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_result_lat; sampleValid |-> ##4 resultValid; endproperty
    a_result_lat: assert property (p_result_lat)
        else $error("result late");
    property p_result_cause; resultValid |-> $past(sampleValid, 4); endproperty
    a_result_cause: assert property (p_result_cause)
        else $error("result without sample");
    property p_comp_time; $changed(resultOut.comp) |-> $past(sampleValid, 2); endproperty
    a_comp_time: assert property (p_comp_time)
        else $error("comp changed off time");
    // Table result only moves with its valid pulse
    property p_lin_hold; !resultValid |-> $stable(resultOut.lin); endproperty
    a_lin_hold: assert property (p_lin_hold)
        else $error("lin moved");
    property p_ready_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("ready timing");
    property p_ready_cause; pready |-> psel && penable && $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without access");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_rdata_zero; pready && (pwrite || pslverr) |-> prdata == 32'h0; endproperty
    a_rdata_zero: assert property (p_rdata_zero)
        else $error("read data not zero");
    ////////////////////////////////////////////////////////////////////////////
    c_result: cover property (resultValid);
    c_error: cover property (pready && pslverr);
    c_write: cover property (pready && pwrite);
endmodule // hall_comp_monitor

bind hall_comp_linearizer hall_comp_monitor mon (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .resultValid(resultValid), .resultOut(resultOut)
);

// ===== hall_comp_pkg.sv
package hall_comp_pkg;

    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_GAIN_TRIM = 10'h003;
    localparam logic [9:0] IDX_GAIN_TC1 = 10'h004;
    localparam logic [9:0] IDX_GAIN_TC2 = 10'h005;
    localparam logic [9:0] IDX_OFFSET_TRIM = 10'h006;
    localparam logic [9:0] IDX_OFFSET_DRIFT = 10'h007;
    localparam logic [9:0] IDX_LIN_FIRST = 10'h00a;
    localparam logic [9:0] IDX_LIN_LAST = 10'h012;
    localparam logic [9:0] IDX_STATUS = 10'h020;

    // Reset values
    localparam logic [23:0] RST_GAIN_TRIM = 24'h000000;
    localparam logic [23:0] RST_GAIN_TC1 = 24'h000000;
    localparam logic [23:0] RST_GAIN_TC2 = 24'h000000;
    localparam logic [23:0] RST_OFFSET_TRIM = 24'h000000;
    localparam logic [23:0] RST_OFFSET_DRIFT = 24'h000000;
    localparam logic [23:0] RST_LIN = 24'h000000;

    // Field positions
    localparam int POL_BIT = 15;
    localparam int COARSE_LSB = 12;
    localparam int FINE_LSB = 0;
    localparam int TC1_WARM_LSB = 0;
    localparam int TC1_COOL_LSB = 12;
    localparam int TC2_WARM_LSB = 0;
    localparam int TC2_COOL_LSB = 12;
    localparam int FINE_OFFSET_LSB = 0;
    localparam int DRIFT_WARM_LSB = 0;
    localparam int DRIFT_COOL_LSB = 12;
    localparam int LIN_EVEN_LSB = 0;
    localparam int LIN_ODD_LSB = 12;
    localparam int LIN_ENABLE_BIT = 12;
    localparam int LIN_BIN_BIT = 13;
    localparam int LIN_OUT_INV_BIT = 14;
    localparam int LIN_IN_INV_BIT = 15;
    localparam int STATUS_LIN_LSB = 0;
    localparam int STATUS_COMP_LSB = 16;

    // Arithmetic constants
    localparam int REF_TEMP_C = 25;
    localparam int TC2_DIV = 1000;
    localparam int TC_DIV = 100;
    localparam int FINE_HALF = 1024;
    localparam int FINE_SHIFT = 11;
    localparam int FACTOR_FRAC = 16;
    localparam int COARSE_MAX_SHIFT = 5;
    localparam int SENS_WIDTH = 17;
    localparam int COMP_WIDTH = 13;
    localparam int LIN_POINTS = 17;
    localparam int LIN_REGS = 9;
    localparam int Y_FIRST = -2048;
    localparam int Y_STEP = 256;
    localparam int Y_MIN = -2304;
    localparam int Y_MAX = 2304;

    typedef struct packed {
        logic signed [15:0] field;
        logic signed [8:0] tempC;
    } sample_s;

    typedef struct packed {
        logic signed [12:0] comp;
        logic signed [12:0] lin;
    } result_s;

endpackage

// ===== hall_front_end.sv
`timescale 1ns/1ps
module hall_front_end (
    input wire logic clk_sys,
    output logic sampleValid,
    output hall_comp_pkg::sample_s sampleIn
);
    initial begin
        sampleValid = 1'b0;
        sampleIn = '0;
    end
    // Called right after a rising edge
    task automatic send(input logic signed [15:0] f, input logic signed [8:0] t);
        sampleValid <= 1'b1;
        sampleIn <= {f, t};
        @(posedge clk_sys);
        sampleValid <= 1'b0;
        // Released bus never shows the last value
        sampleIn <= ~{f, t};
    endtask
endmodule // hall_front_end

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, sampleValid, resultValid, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    hall_comp_pkg::sample_s sampleIn;
    hall_comp_pkg::result_s resultOut;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    hall_comp_linearizer dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sampleValid(sampleValid), .sampleIn(sampleIn),
        .resultValid(resultValid), .resultOut(resultOut));
    hall_front_end fe (.clk_sys(clk_sys), .sampleValid(sampleValid), .sampleIn(sampleIn));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Entered right after a rising edge; pready read at the edge is the sampled value
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check({31'h0, pready}, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never re-raises psel in the same step
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 4'hf);
    endtask

    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic e);
        apb(1'b0, idx, 32'h0, 4'h0);
        check(rd, exp);
        check({31'h0, err}, {31'h0, e});
    endtask

    task automatic samp(input logic signed [15:0] f, input logic signed [8:0] t,
                        input logic signed [12:0] ec, input logic signed [12:0] el);
        int n;
        n = 0;
        fe.send(f, t);
        do begin
            @(negedge clk_sys);
            n++;
        end while (resultValid !== 1'b1 && n < 10);
        check(n, 4);
        check(32'(resultOut.comp), 32'(ec));
        check(32'(resultOut.lin), 32'(el));
        @(posedge clk_sys);
    endtask

    function automatic logic [11:0] xp(input int k);
        return 12'(64 * k - 512);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdchk(hall_comp_pkg::IDX_GAIN_TRIM, 32'h0, 1'b0);
        rdchk(hall_comp_pkg::IDX_GAIN_TC1, 32'h0, 1'b0);
        rdchk(hall_comp_pkg::IDX_GAIN_TC2, 32'h0, 1'b0);
        rdchk(hall_comp_pkg::IDX_OFFSET_TRIM, 32'h0, 1'b0);
        rdchk(hall_comp_pkg::IDX_OFFSET_DRIFT, 32'h0, 1'b0);
        rdchk(hall_comp_pkg::IDX_LIN_LAST, 32'h0, 1'b0);
        rdchk(10'h3f0, 32'h0, 1'b1);
        apb(1'b1, 10'h3f0, 32'h0000ffff, 4'hf);
        check({31'h0, err}, 32'h1);
        apb(1'b1, hall_comp_pkg::IDX_GAIN_TRIM, 32'hffabcdef, 4'h3);
        rdchk(hall_comp_pkg::IDX_GAIN_TRIM, 32'h0000cdef, 1'b0);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'hffabcdef);
        rdchk(hall_comp_pkg::IDX_GAIN_TRIM, 32'h00abcdef, 1'b0);
        wr(hall_comp_pkg::IDX_STATUS, 32'h00ffffff);
        rdchk(hall_comp_pkg::IDX_STATUS, 32'h0, 1'b0);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h0);
    endtask

    task automatic t_gain;
        samp(1000, 25, 500, 500);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h000400);
        samp(1000, 25, 1000, 1000);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h001400);
        samp(1000, 25, 2000, 2000);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h009400);
        samp(1000, 25, -2000, -2000);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h006400);
        samp(100, 25, 3200, 3200);
        samp(200, 25, 4095, 4095);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h00e400);
        samp(200, 25, -4096, -4096);
        wr(hall_comp_pkg::IDX_GAIN_TRIM, 32'h000400);
    endtask

    task automatic t_temp;
        wr(hall_comp_pkg::IDX_GAIN_TC1, 32'h140280);
        samp(1000, 45, 1500, 1500);
        samp(1000, 5, 750, 750);
        samp(1000, 25, 1000, 1000);
        wr(hall_comp_pkg::IDX_GAIN_TC1, 32'h0);
        wr(hall_comp_pkg::IDX_GAIN_TC2, 32'h0280a0);
        samp(1000, 225, 1250, 1250);
        samp(1600, -175, 1700, 1700);
        wr(hall_comp_pkg::IDX_GAIN_TC2, 32'h0);
        wr(hall_comp_pkg::IDX_OFFSET_TRIM, 32'h000064);
        samp(1000, 25, 1100, 1100);
        wr(hall_comp_pkg::IDX_OFFSET_DRIFT, 32'h080040);
        samp(1000, 35, 1110, 1110);
        samp(1000, 15, 1080, 1080);
        wr(hall_comp_pkg::IDX_OFFSET_DRIFT, 32'h0);
        wr(hall_comp_pkg::IDX_OFFSET_TRIM, 32'h0);
    endtask

    task automatic t_table;
        // Ascending points, 64 apart from -512
        for (int k = 0; k < 8; k++) begin
            wr(hall_comp_pkg::IDX_LIN_FIRST + 10'(k), {8'h00, xp(2 * k + 1), xp(2 * k)});
        end
        wr(hall_comp_pkg::IDX_LIN_LAST, {16'h0000, 4'h1, xp(16)});
        samp(0, 25, 0, 0);
        samp(-480, 25, -480, -1920);
        samp(-560, 25, -560, -2240);
        samp(-1000, 25, -1000, -2304);
        samp(530, 25, 530, 2120);
        samp(1000, 25, 1000, 2304);
        samp(512, 25, 512, 2048);
        wr(hall_comp_pkg::IDX_LIN_LAST, {16'h0000, 4'h3, xp(16)});
        samp(40, 25, 40, 0);
        samp(100, 25, 100, 256);
        samp(-1000, 25, -1000, -2304);
        samp(1000, 25, 1000, 2048);
        wr(hall_comp_pkg::IDX_LIN_FIRST + 10'h004, {8'h00, xp(8), xp(8)});
        samp(0, 25, 0, 256);
        samp(-1, 25, -1, -256);
        wr(hall_comp_pkg::IDX_LIN_LAST, {16'h0000, 4'h5, xp(16)});
        samp(-480, 25, -480, 1920);
        wr(hall_comp_pkg::IDX_LIN_LAST, {16'h0000, 4'h9, xp(16)});
        samp(480, 25, 480, -1920);
        rdchk(hall_comp_pkg::IDX_STATUS, 32'h01e01880, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 5000) begin
            bad_count++;
            wrap_up;
        end
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_regs;
        t_gain;
        t_temp;
        t_table;
        wrap_up;
    end
endmodule // testbench
